/* File: hdl/eer_consts.vh */
// constants for the exception entry and return unit
// assumes a single 25 MHz core clock and a plain register port
`ifndef EER_CONSTS_VH
`define EER_CONSTS_VH

// register offsets (byte addresses)
`define EER_FP_CONTEXT_CONTROL 32'hE000_EF34
`define EER_AUX_CONTROL 32'hE000_E008
`define EER_STATUS 32'hE000_EF40

// field positions
`define EER_LAZY_SAVE_ENABLE_BIT 30
`define EER_DEFAULT_WRITE_BUFFER_DISABLE 1

// reset values
`define EER_FP_CONTEXT_CONTROL_RST 32'h4000_0000
`define EER_AUX_CONTROL_RST 32'h0000_0000

// timing counts in core clock cycles
`define EER_FP_DIV_CYCLES 14
`define EER_STACK_CYCLES 5'h0c
`define EER_FP_STACK_CYCLES 5'h12

// exception sequencer states
`define EER_ST_RUN 3'd0
`define EER_ST_STACK 3'd1
`define EER_ST_HANDLER 3'd2
`define EER_ST_RET_WAIT 3'd3
`define EER_ST_UNSTACK 3'd4

`endif

/* File: hdl/eer_fp_div.v */
// fixed-latency floating-point divide / square-root unit
// assumes start pulses only while busy is low
`timescale 1ns/10ps
`include "eer_consts.vh"

module eer_fp_div #(
	parameter LATENCY = `EER_FP_DIV_CYCLES
) (
	// clock and reset
	input wire ref_clk,
	input wire resetn,
	// operation start
	input wire start,
	input wire [4:0] dst,
	// progress and completion
	output reg busy,
	output reg done,
	output reg [4:0] done_dst
);

reg [4:0] count;

// count the fixed occupancy, never aborted by exceptions
always @(posedge ref_clk or negedge resetn) begin
	if (!resetn) begin
		busy <= 1'b0;
		done <= 1'b0;
		done_dst <= 5'h00;
		count <= 5'h00;
	end else begin
		done <= 1'b0;
		if (start && !busy) begin
			busy <= 1'b1;
			count <= LATENCY[4:0] - 5'd1;
			done_dst <= dst;
		end else if (busy) begin
			if (count == 5'd1) begin
				busy <= 1'b0;
				done <= 1'b1;
			end
			count <= count - 5'd1;
		end
	end
end

endmodule // eer_fp_div

/* File: hdl/eer_core.v */
// exception entry and return unit of a small embedded core
// assumes interrupt controller, pipeline and bus all on ref_clk
//
// How it works
// - interrupted stack-pointer load replays after return
// - replayed load never repeats base writeback
// - divide/root runs 14 cycles through stacking
// - lazy save defers fp stacking to first fp op
// - lazy save on at reset; 12+ entry cycles
// - return waits for divide, result always written
// - stack wait states just stretch the stacking
// - write buffer lets execution pass pending stores
// - buffered store drains before return re-arbitrates
// - acknowledged interrupt and fetched vector always match
`timescale 1ns/10ps
`include "eer_consts.vh"

module eer_core #(
	parameter NUM_W = 8,
	parameter PRIO_W = 8
) (
	// clock and reset
	input wire ref_clk,
	input wire resetn,
	// register port
	input wire [31:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [31:0] reg_rdata,
	// interrupt controller
	input wire irq_req,
	input wire [NUM_W-1:0] irq_num,
	input wire [PRIO_W-1:0] irq_prio,
	output reg irq_ack,
	output reg [NUM_W-1:0] irq_ack_num,
	output reg vector_fetch,
	output reg [NUM_W-1:0] vector_num,
	output reg [PRIO_W-1:0] exec_prio,
	output wire exc_active,
	// pipeline events
	input wire sp_load_issue,
	input wire sp_load_writeback,
	input wire sp_load_done,
	input wire exc_return,
	output reg sp_load_replay,
	output reg sp_base_update,
	output reg handler_start,
	output reg return_done,
	// stacking bus
	input wire fp_ctx_live,
	input wire stack_ready,
	output wire stack_req,
	// floating-point unit
	input wire fp_div_start,
	input wire [4:0] fp_div_dst,
	input wire fp_op_in_handler,
	output reg fp_result_we,
	output reg [4:0] fp_result_dst,
	output reg fp_status_we,
	output reg fp_ctx_stack,
	output wire fp_div_busy,
	// store path and write buffer
	input wire st_valid,
	input wire [31:0] st_addr,
	input wire [31:0] st_data,
	input wire st_bufferable,
	output wire st_ready,
	output wire core_stall,
	input wire dsb_req,
	output reg dsb_done,
	output reg bus_wr_valid,
	output reg [31:0] bus_wr_addr,
	output reg [31:0] bus_wr_data,
	input wire bus_wr_ready
);

// ****************************************
// declarations
// ****************************************
reg [2:0] state;
reg [2:0] next_state;
reg [4:0] stack_cnt;
reg lazy_en;
reg wb_disable;
reg lazy_pending;
reg load_in_flight;
reg load_wb_form;
reg load_wb_applied;
reg replay_pending;
reg wb_bufferable;
reg dsb_pend;
reg [PRIO_W-1:0] saved_prio;
wire div_done;
wire [4:0] div_done_dst;
wire stack_last;
wire take_irq;
wire ret_clear;
wire st_accept;

// ****************************************
// floating-point divider
// ****************************************
// fixed occupancy, not aborted on entry
eer_fp_div #(
	.LATENCY(`EER_FP_DIV_CYCLES)
) u_div (
	.ref_clk(ref_clk),
	.resetn(resetn),
	.start(fp_div_start),
	.dst(fp_div_dst),
	.busy(fp_div_busy),
	.done(div_done),
	.done_dst(div_done_dst)
);

always @(posedge ref_clk or negedge resetn) begin
	if (!resetn) begin
		fp_result_we <= 1'b0;
		fp_status_we <= 1'b0;
		fp_result_dst <= 5'h00;
	end else begin
		fp_result_we <= div_done;
		fp_status_we <= div_done;
		if (div_done) begin
			fp_result_dst <= div_done_dst;
		end
	end
end

// ****************************************
// exception sequencer
// ****************************************
assign exc_active = (state != `EER_ST_RUN);
assign stack_req = (state == `EER_ST_STACK) || (state == `EER_ST_UNSTACK);
assign stack_last = stack_ready && (stack_cnt == 5'd1);
assign take_irq = irq_req && (state == `EER_ST_RUN) && !bus_wr_valid;
// return re-arbitrates only with buffer drained
// and with no divide still in flight
assign ret_clear = !bus_wr_valid && !fp_div_busy;

// next state
always @* begin
	next_state = state;
	case (state)
		`EER_ST_RUN: begin
			if (take_irq) begin
				next_state = `EER_ST_STACK;
			end
		end
		`EER_ST_STACK: begin
			if (stack_last) begin
				next_state = `EER_ST_HANDLER;
			end
		end
		`EER_ST_HANDLER: begin
			if (exc_return) begin
				next_state = `EER_ST_RET_WAIT;
			end
		end
		`EER_ST_RET_WAIT: begin
			if (ret_clear) begin
				next_state = `EER_ST_UNSTACK;
			end
		end
		`EER_ST_UNSTACK: begin
			if (stack_last) begin
				next_state = `EER_ST_RUN;
			end
		end
		default: begin
			next_state = `EER_ST_RUN;
		end
	endcase
end

// state register, stacking count and interrupt handshake
always @(posedge ref_clk or negedge resetn) begin
	if (!resetn) begin
		state <= `EER_ST_RUN;
		stack_cnt <= 5'h00;
		irq_ack <= 1'b0;
		irq_ack_num <= {NUM_W{1'b0}};
		vector_fetch <= 1'b0;
		vector_num <= {NUM_W{1'b0}};
		exec_prio <= {PRIO_W{1'b1}};
		saved_prio <= {PRIO_W{1'b1}};
		handler_start <= 1'b0;
		return_done <= 1'b0;
	end else begin
		state <= next_state;
		irq_ack <= 1'b0;
		vector_fetch <= 1'b0;
		handler_start <= 1'b0;
		return_done <= 1'b0;
		if (take_irq) begin
			// ack and vector from one latched choice
			irq_ack <= 1'b1;
			vector_fetch <= 1'b1;
			irq_ack_num <= irq_num;
			vector_num <= irq_num;
			saved_prio <= exec_prio;
			exec_prio <= irq_prio;
			// at least 12 cycles before the handler
			// fp words added only when lazy save is off
			if (fp_ctx_live && !lazy_en) begin
				stack_cnt <= `EER_STACK_CYCLES + `EER_FP_STACK_CYCLES;
			end else begin
				stack_cnt <= `EER_STACK_CYCLES;
			end
		end else if (state == `EER_ST_RET_WAIT && ret_clear) begin
			stack_cnt <= `EER_STACK_CYCLES;
		end else if (stack_req && stack_ready) begin
			// a cycle without stack_ready just waits
			stack_cnt <= stack_cnt - 5'd1;
		end
		if (state == `EER_ST_STACK && stack_last) begin
			handler_start <= 1'b1;
		end
		if (state == `EER_ST_UNSTACK && stack_last) begin
			return_done <= 1'b1;
			exec_prio <= saved_prio;
		end
	end
end

// ****************************************
// lazy floating-point context
// ****************************************
// fp context stacked on first handler fp op
always @(posedge ref_clk or negedge resetn) begin
	if (!resetn) begin
		lazy_pending <= 1'b0;
		fp_ctx_stack <= 1'b0;
	end else begin
		fp_ctx_stack <= 1'b0;
		if (take_irq) begin
			lazy_pending <= fp_ctx_live && lazy_en;
		end else if (lazy_pending && fp_op_in_handler && state == `EER_ST_HANDLER) begin
			lazy_pending <= 1'b0;
			fp_ctx_stack <= 1'b1;
		end else if (state == `EER_ST_UNSTACK) begin
			lazy_pending <= 1'b0;
		end
	end
end

// ****************************************
// stack-pointer load tracking
// ****************************************
// an interrupted load is replayed on return
always @(posedge ref_clk or negedge resetn) begin
	if (!resetn) begin
		load_in_flight <= 1'b0;
		load_wb_form <= 1'b0;
		load_wb_applied <= 1'b0;
		replay_pending <= 1'b0;
		sp_load_replay <= 1'b0;
		sp_base_update <= 1'b0;
	end else begin
		sp_load_replay <= 1'b0;
		sp_base_update <= 1'b0;
		if (sp_load_issue && !exc_active) begin
			load_in_flight <= 1'b1;
			load_wb_form <= sp_load_writeback;
			load_wb_applied <= 1'b0;
		end else if (take_irq && load_in_flight) begin
			replay_pending <= 1'b1;
		end else if (state == `EER_ST_UNSTACK && stack_last && replay_pending) begin
			replay_pending <= 1'b0;
			sp_load_replay <= 1'b1;
		end else if (sp_load_done && load_in_flight && !exc_active) begin
			load_in_flight <= 1'b0;
			load_wb_applied <= 1'b1;
			sp_base_update <= load_wb_form && !load_wb_applied;
		end
	end
end

// ****************************************
// write buffer
// ****************************************
// one entry, execution continues past it
// disable bit or non-bufferable store stalls
assign st_ready = !bus_wr_valid;
assign st_accept = st_valid && st_ready;
assign core_stall = bus_wr_valid && (wb_disable || !wb_bufferable || dsb_pend);

always @(posedge ref_clk or negedge resetn) begin
	if (!resetn) begin
		bus_wr_valid <= 1'b0;
		bus_wr_addr <= 32'h0000_0000;
		bus_wr_data <= 32'h0000_0000;
		wb_bufferable <= 1'b0;
	end else if (st_accept) begin
		bus_wr_valid <= 1'b1;
		bus_wr_addr <= st_addr;
		bus_wr_data <= st_data;
		wb_bufferable <= st_bufferable;
	end else if (bus_wr_ready) begin
		bus_wr_valid <= 1'b0;
	end
end

// barrier completes once the buffer is empty
always @(posedge ref_clk or negedge resetn) begin
	if (!resetn) begin
		dsb_pend <= 1'b0;
		dsb_done <= 1'b0;
	end else begin
		dsb_done <= 1'b0;
		if ((dsb_req || dsb_pend) && !bus_wr_valid) begin
			dsb_pend <= 1'b0;
			dsb_done <= 1'b1;
		end else if (dsb_req) begin
			dsb_pend <= 1'b1;
		end
	end
end

// ****************************************
// register port
// ****************************************
// lazy save enabled out of reset
// software clears the lazy save enable bit
always @(posedge ref_clk or negedge resetn) begin
	if (!resetn) begin
		lazy_en <= 1'b1;
		wb_disable <= 1'b0;
	end else if (reg_wr) begin
		if (reg_addr == `EER_FP_CONTEXT_CONTROL) begin
			lazy_en <= reg_wdata[`EER_LAZY_SAVE_ENABLE_BIT];
		end
		if (reg_addr == `EER_AUX_CONTROL) begin
			wb_disable <= reg_wdata[`EER_DEFAULT_WRITE_BUFFER_DISABLE];
		end
	end
end

// read data valid only in the cycle after the strobe
always @(posedge ref_clk or negedge resetn) begin
	if (!resetn) begin
		reg_rdata <= 32'h0000_0000;
	end else begin
		reg_rdata <= 32'h0000_0000;
		if (reg_rd) begin
			case (reg_addr)
				`EER_FP_CONTEXT_CONTROL: begin
					reg_rdata[`EER_LAZY_SAVE_ENABLE_BIT] <= lazy_en;
				end
				`EER_AUX_CONTROL: begin
					reg_rdata[`EER_DEFAULT_WRITE_BUFFER_DISABLE] <= wb_disable;
				end
				`EER_STATUS: begin
					reg_rdata <= {24'h00_0000, replay_pending, dsb_pend, bus_wr_valid,
						fp_div_busy, lazy_pending, state};
				end
				default: begin
					reg_rdata <= 32'h0000_0000;
				end
			endcase
		end
	end
end

endmodule // eer_core

/* File: dv/eer_far_side.sv */
// far side model: interrupt controller and memory bus
// assumes one ref_clk domain shared with the core
`timescale 1ns/10ps
module eer_far_side (
	// clock and reset
	input wire ref_clk,
	input wire resetn,
	// bench control
	input wire slow,
	input wire raise,
	input wire [7:0] num_in,
	// core side
	input wire irq_ack,
	output reg irq_req,
	output reg [7:0] irq_num,
	output wire [7:0] irq_prio,
	output wire stack_ready,
	output wire bus_wr_ready
);
	// ****************
	// far side logic
	// ****************
	reg [1:0] ws;
	assign irq_prio = ~irq_num;
	assign stack_ready = !slow || ws == 2'h0;
	assign bus_wr_ready = stack_ready;
	// level request held until acknowledged
	always @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			irq_req <= 1'h0;
			irq_num <= 8'h00;
			ws <= 2'h0;
		end else begin
			ws <= ws + 2'h1;
			if (raise) begin
				irq_req <= 1'h1;
				irq_num <= num_in;
			end else if (irq_ack) begin
				irq_req <= 1'h0;
			end
		end
	end
endmodule // eer_far_side

/* File: dv/eer_core_assertions.sv */
// checker for the exception entry and return unit
// assumes it is bound to eer_core, one clock
`timescale 1ns/10ps
module eer_core_assertions #(
	parameter NUM_W = 8
) (
	// clock and reset
	input wire ref_clk,
	input wire resetn,
	// watched ports
	input wire irq_req,
	input wire irq_ack,
	input wire [NUM_W-1:0] irq_ack_num,
	input wire vector_fetch,
	input wire [NUM_W-1:0] vector_num,
	input wire exc_active,
	input wire handler_start,
	input wire return_done,
	input wire sp_load_done,
	input wire sp_load_replay,
	input wire sp_base_update,
	input wire fp_div_start,
	input wire fp_div_busy,
	input wire fp_result_we,
	input wire fp_status_we,
	input wire bus_wr_valid
);
	// ************
	// properties
	// ************
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	ack_vector_a: assert property (irq_ack |-> vector_fetch && vector_num == irq_ack_num)
		else $error("vector differs from ack");
	entry_take_a: assert property (irq_req && !exc_active && !bus_wr_valid |=> irq_ack)
		else $error("interrupt not taken");
	entry_min_a: assert property (irq_ack |=> (!handler_start)[*8] ##1 (!handler_start)[*3])
		else $error("handler started too early");
	ret_clean_a: assert property (return_done |-> !fp_div_busy && !bus_wr_valid)
		else $error("return with work pending");
	div_lat_a: assert property (fp_div_start && !fp_div_busy |-> ##15 fp_result_we)
		else $error("divide result missing");
	status_we_a: assert property (fp_result_we |-> fp_status_we)
		else $error("status not written");
	base_once_a: assert property (sp_base_update |-> $past(sp_load_done))
		else $error("base update without load");
	replay_ret_a: assert property (sp_load_replay |-> return_done)
		else $error("replay outside return");
endmodule // eer_core_assertions
bind eer_core eer_core_assertions #(.NUM_W(NUM_W)) eer_core_assertions_i (
	.ref_clk(ref_clk), .resetn(resetn), .irq_req(irq_req), .irq_ack(irq_ack),
	.irq_ack_num(irq_ack_num), .vector_fetch(vector_fetch), .vector_num(vector_num),
	.exc_active(exc_active), .handler_start(handler_start), .return_done(return_done),
	.sp_load_done(sp_load_done), .sp_load_replay(sp_load_replay), .sp_base_update(sp_base_update),
	.fp_div_start(fp_div_start), .fp_div_busy(fp_div_busy), .fp_result_we(fp_result_we),
	.fp_status_we(fp_status_we), .bus_wr_valid(bus_wr_valid)
);

/* File: dv/eer_core_tb.sv */
// testbench for the exception entry and return unit
// assumes the far side model and the bound checker
`timescale 1ns/10ps
`include "eer_consts.vh"
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin errors++; $display("[ERR] %0t %h %h", $time, a, e); end end
module eer_core_tb;
	// ***********
	// bench
	// ***********
	reg ref_clk = 1'h0, resetn = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0, slow = 1'h0, raise = 1'h0;
	reg sp_load_issue = 1'h0, sp_load_writeback = 1'h0, sp_load_done = 1'h0, exc_return = 1'h0;
	reg fp_div_start = 1'h0, st_valid = 1'h0, tie1 = 1'h1, fp_ctx_live = 1'h0, fp_op_in_handler = 1'h0;
	reg dsb_req = 1'h0;
	reg [31:0] reg_addr = 32'h0000_0000, reg_wdata = 32'h0000_0000, st_addr = 32'h0000_0000;
	reg [31:0] st_data = 32'h0000_0000, r = 32'h0000_0000;
	reg [4:0] fp_div_dst = 5'h00;
	reg [7:0] num = 8'h00;
	wire [31:0] reg_rdata;
	wire [7:0] irq_num, irq_prio;
	wire [4:0] fp_result_dst;
	wire irq_req, irq_ack, handler_start, return_done, sp_load_replay, sp_base_update;
	wire stack_ready, fp_result_we, core_stall, bus_wr_valid, bus_wr_ready;
	wire [7:0] exec_prio, vector_num;
	wire [31:0] bus_wr_addr, bus_wr_data;
	wire stack_req, st_ready, dsb_done, fp_ctx_stack;
	int cyc = 0, t_ack = 0, t_hs = 0, n_fcs = 0, n_dsb = 0, sync = 0;
	integer seed;
	int errors = 0, compares = 0, n_ack = 0, n_hs = 0, n_ret = 0, n_res = 0, n_rep = 0, n_base = 0;
	logic [4:0] exp_q[$];
	always #20 ref_clk = ~ref_clk;
	eer_core eer_core_i (.ref_clk(ref_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_req(irq_req), .irq_num(irq_num),
		.irq_prio(irq_prio), .irq_ack(irq_ack), .irq_ack_num(), .vector_fetch(), .vector_num(vector_num),
		.exec_prio(exec_prio), .exc_active(), .sp_load_issue(sp_load_issue),
		.sp_load_writeback(sp_load_writeback),
		.sp_load_done(sp_load_done), .exc_return(exc_return), .sp_load_replay(sp_load_replay),
		.sp_base_update(sp_base_update), .handler_start(handler_start), .return_done(return_done),
		.fp_ctx_live(fp_ctx_live), .stack_ready(stack_ready), .stack_req(stack_req),
		.fp_div_start(fp_div_start),
		.fp_div_dst(fp_div_dst), .fp_op_in_handler(fp_op_in_handler), .fp_result_we(fp_result_we),
		.fp_result_dst(fp_result_dst), .fp_status_we(), .fp_ctx_stack(fp_ctx_stack), .fp_div_busy(),
		.st_valid(st_valid), .st_addr(st_addr), .st_data(st_data), .st_bufferable(tie1),
		.st_ready(st_ready),
		.core_stall(core_stall), .dsb_req(dsb_req), .dsb_done(dsb_done), .bus_wr_valid(bus_wr_valid),
		.bus_wr_addr(bus_wr_addr), .bus_wr_data(bus_wr_data), .bus_wr_ready(bus_wr_ready));
	eer_far_side eer_far_side_i (.ref_clk(ref_clk), .resetn(resetn), .slow(slow), .raise(raise),
		.num_in(num), .irq_ack(irq_ack), .irq_req(irq_req), .irq_num(irq_num), .irq_prio(irq_prio),
		.stack_ready(stack_ready), .bus_wr_ready(bus_wr_ready));
	// pulse counters and divide result model
	always @(posedge ref_clk) begin
		cyc++;
		if (irq_ack) t_ack = cyc;
		if (handler_start) t_hs = cyc;
		if (fp_ctx_stack) n_fcs++;
		if (dsb_done) n_dsb++;
		if (irq_ack) n_ack++;
		if (handler_start) n_hs++;
		if (return_done) n_ret++;
		if (sp_load_replay) n_rep++;
		if (sp_base_update) n_base++;
		if (fp_result_we) begin
			n_res++;
			`CHK(fp_result_dst, exp_q.pop_front())
		end
	end
	task complete_run;
		$display("errors=%0d compares=%0d", errors, compares);
		if (errors == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic wait_for(ref int c, input int n);
		int k;
		k = 0;
		while (c < n && k < 300) begin
			@(posedge ref_clk);
			k++;
		end
		if (c < n) begin
			errors++;
			complete_run;
		end
	endtask
	task wr(input [31:0] a, input [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		@(posedge ref_clk);
		reg_wr <= 1'h0;
		@(posedge ref_clk);
	endtask
	task rd(input [31:0] a, input [31:0] e);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge ref_clk);
		reg_rd <= 1'h0;
		@(posedge ref_clk);
		`CHK(reg_rdata, e)
	endtask
	task ret;
		exc_return <= 1'h1;
		@(posedge ref_clk);
		exc_return <= 1'h0;
		@(posedge ref_clk);
	endtask
	initial begin
		seed = 32'hae9e_44f9;
		repeat (3) @(posedge ref_clk);
		resetn <= 1'h1;
		@(posedge ref_clk);
		// register reset values, bit 30 only, unmapped
		rd(`EER_FP_CONTEXT_CONTROL, `EER_FP_CONTEXT_CONTROL_RST);
		rd(32'h0000_0010, 32'h0000_0000);
		wr(`EER_FP_CONTEXT_CONTROL, 32'h0000_0000);
		rd(`EER_FP_CONTEXT_CONTROL, 32'h0000_0000);
		wr(`EER_FP_CONTEXT_CONTROL, 32'hffff_ffff);
		rd(`EER_FP_CONTEXT_CONTROL, 32'h4000_0000);
		r = $random(seed);
		wr(`EER_AUX_CONTROL, r);
		rd(`EER_AUX_CONTROL, r & 32'h0000_0002);
		wr(`EER_AUX_CONTROL, 32'h0000_0000);
		// divide overlapped by a short handler
		r = $random(seed);
		fp_div_dst <= {1'h0, r[3:0]};
		exp_q.push_back({1'h0, r[3:0]});
		fp_div_start <= 1'h1;
		num <= r[15:8];
		raise <= 1'h1;
		@(posedge ref_clk);
		fp_div_start <= 1'h0;
		raise <= 1'h0;
		wait_for(n_hs, 1);
		`CHK(t_hs - t_ack, `EER_STACK_CYCLES)
		`CHK(stack_req, 1'h0)
		ret;
		wait_for(n_ret, 1);
		wait_for(n_res, 1);
		// interrupted stack-pointer load with writeback
		num <= r[23:16];
		sp_load_issue <= 1'h1;
		sp_load_writeback <= 1'h1;
		raise <= 1'h1;
		@(posedge ref_clk);
		sp_load_issue <= 1'h0;
		sp_load_writeback <= 1'h0;
		raise <= 1'h0;
		wait_for(n_hs, 2);
		ret;
		wait_for(n_ret, 2);
		`CHK(n_rep, 1)
		sp_load_done <= 1'h1;
		@(posedge ref_clk);
		sp_load_done <= 1'h0;
		repeat (3) @(posedge ref_clk);
		`CHK(n_base, 1)
		// buffered stores on a slow bus
		r = $random(seed);
		slow <= 1'h1;
		st_addr <= r;
		st_data <= ~r;
		st_valid <= 1'h1;
		num <= r[7:0];
		raise <= 1'h1;
		@(posedge ref_clk);
		st_valid <= 1'h0;
		raise <= 1'h0;
		wait_for(n_hs, 3);
		`CHK(vector_num, r[7:0])
		`CHK(exec_prio, ~r[7:0])
		`CHK(bus_wr_addr, r)
		`CHK(bus_wr_data, ~r)
		st_valid <= 1'h1;
		@(posedge ref_clk);
		st_valid <= 1'h0;
		ret;
		wait_for(n_ret, 3);
		`CHK(n_ack, 3)
		`CHK(exec_prio, 8'hff)
		// disabled buffer makes stores blocking
		wr(`EER_AUX_CONTROL, 32'h0000_0002);
		st_valid <= 1'h1;
		@(posedge ref_clk);
		st_valid <= 1'h0;
		@(posedge ref_clk);
		`CHK(core_stall, 1'h1)
		repeat (10) @(posedge ref_clk);
		`CHK(bus_wr_valid, 1'h0)
		// lazy save on: fp context stacked at first handler fp op
		slow <= 1'h0;
		fp_ctx_live <= 1'h1;
		raise <= 1'h1;
		@(posedge ref_clk);
		raise <= 1'h0;
		wait_for(n_hs, 4);
		`CHK(t_hs - t_ack, `EER_STACK_CYCLES)
		fp_div_dst <= {1'h0, r[19:16]};
		exp_q.push_back({1'h0, r[19:16]});
		fp_div_start <= 1'h1;
		fp_op_in_handler <= 1'h1;
		@(posedge ref_clk);
		fp_div_start <= 1'h0;
		fp_op_in_handler <= 1'h0;
		ret;
		wait_for(n_ret, 4);
		`CHK(n_res, 2)
		`CHK(n_fcs, 1)
		// lazy save off: fp words stacked on entry
		wr(`EER_FP_CONTEXT_CONTROL, 32'h0000_0000);
		raise <= 1'h1;
		@(posedge ref_clk);
		raise <= 1'h0;
		wait_for(n_hs, 5);
		`CHK(t_hs - t_ack, `EER_STACK_CYCLES + `EER_FP_STACK_CYCLES)
		fp_op_in_handler <= 1'h1;
		@(posedge ref_clk);
		fp_op_in_handler <= 1'h0;
		ret;
		wait_for(n_ret, 5);
		`CHK(n_fcs, 1)
		fp_ctx_live <= 1'h0;
		// barrier holds until the buffered store drains
		wr(`EER_AUX_CONTROL, 32'h0000_0000);
		slow <= 1'h1;
		@(posedge ref_clk);
		while (!stack_ready && sync < 4) begin
			@(posedge ref_clk);
			sync++;
		end
		st_valid <= 1'h1;
		@(posedge ref_clk);
		st_valid <= 1'h0;
		dsb_req <= 1'h1;
		@(posedge ref_clk);
		dsb_req <= 1'h0;
		@(posedge ref_clk);
		`CHK(core_stall, 1'h1)
		`CHK(st_ready, 1'h0)
		wait_for(n_dsb, 1);
		`CHK(bus_wr_valid, 1'h0)
		complete_run;
	end
endmodule // eer_core_tb
